// ---- verilog/deio_pkg.sv ----
// constants and types for the dual-edge pad register path
// assumes one core clock; pads are modelled as plain logic levels
// Behaviour
// - bypass mode wires core data straight to and from the pad buffer.
// - single-register mode uses one ordinary register per pin, one bit per clock.
// - ddr mode moves one bit on each clock edge per pin.
// - asynchronous clear input exists only in ddr mode and clears path registers.
// - asynchronous preset only for output or bidir ddr, power-up-high off.
// - without clear, preset or sync clear, ddr registers power up per power-up-high.
// - ddr with exposed enables loads only while enable high, else every clock.
// - output-direction ddr with inversion drives inverted data out.
// - inverted capture clock takes first bit on falling edge, else rising edge.
// - output enable used when selected for output, always for bidirectional.
// - input or bidir exposes the input-buffer sleep control when selected.
// - bus-hold keeps the pin at the level sampled on the last rising edge while driven; no hold in open-drain mode.
// - open-drain output only pulls low, sharing a wired line.
// - true differential selection uses true differential buffers.
// - pseudo differential: pseudo output buffer; bidir adds true differential input.
// - active-high clear forces register outputs to zero without a clock edge.
// - core word carries two bits per pin in ddr, one otherwise.
// - ddr input: rise register, fall register, and realign of rise on falling edge.
package deio_pkg;
    typedef enum logic [2:0] {
        DEIO_BYPASS = 3'h1,
        DEIO_SINGLE_RATE = 3'h2,
        DEIO_DDR = 3'h4
    } deio_mode_t;
    typedef enum logic [2:0] {
        DEIO_DIR_IN = 3'h1,
        DEIO_DIR_OUT = 3'h2,
        DEIO_DIR_BIDIR = 3'h4
    } deio_dir_t;
    localparam int DEIO_DEF_WIDTH = 4;
    localparam int DEIO_BUF_DEPTH = 2;
    localparam logic DEIO_CLEAR_LEVEL = 1'h0;
    localparam logic DEIO_PRESET_LEVEL = 1'h1;
    localparam logic [1:0] DEIO_EMPTY_COUNT = 2'h0;
endpackage

// ---- verilog/deio_path.sv ----
// dual-edge pad register path: bypass, single-rate and ddr modes
// assumes pads and core run from clock; negative edge used for ddr halves
module deio_path import deio_pkg::*; #(
    parameter int WIDTH = DEIO_DEF_WIDTH,
    parameter deio_dir_t DIR = DEIO_DIR_BIDIR,
    parameter deio_mode_t MODE = DEIO_DDR,
    parameter bit USE_ACLR = 1'b1,
    parameter bit USE_ASET = 1'b0,
    parameter bit POWER_UP_HIGH = 1'b0,
    parameter bit USE_CLKEN = 1'b1,
    parameter bit INVERT_OUT = 1'b0,
    parameter bit INVERT_INCLK = 1'b0,
    parameter bit USE_OE = 1'b1,
    parameter bit USE_SLEEP = 1'b1,
    parameter bit BUS_HOLD = 1'b0,
    parameter bit OPEN_DRAIN = 1'b0,
    parameter bit TRUE_DIFF = 1'b0,
    parameter bit PSEUDO_DIFF = 1'b0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic aclr,
    input wire logic aset,
    input wire logic captureEn,
    input wire logic launchEn,
    input wire logic sleepN,
    input wire logic oe,
    input wire logic [2*WIDTH-1:0] txData,
    input wire logic [WIDTH-1:0] padIn,
    input wire logic [WIDTH-1:0] padInN,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOutN,
    output logic [WIDTH-1:0] padOutEnN,
    output logic [2*WIDTH-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic captureReady
);
    localparam bit IS_DDR = (MODE == DEIO_DDR);
    localparam bit IS_BYP = (MODE == DEIO_BYPASS);
    localparam bit HAS_IN = (DIR != DEIO_DIR_OUT);
    localparam bit HAS_OUT = (DIR != DEIO_DIR_IN);
    localparam bit CLR_OK = IS_DDR && USE_ACLR;
    localparam bit SET_OK = IS_DDR && USE_ASET && HAS_OUT && !POWER_UP_HIGH;
    localparam logic INIT_LEVEL = (IS_DDR && !USE_ACLR && !USE_ASET && POWER_UP_HIGH)
        ? DEIO_PRESET_LEVEL : DEIO_CLEAR_LEVEL;
    localparam logic [WIDTH-1:0] INIT_WORD = {WIDTH{INIT_LEVEL}};
    localparam logic [WIDTH-1:0] CLR_WORD = {WIDTH{DEIO_CLEAR_LEVEL}};
    localparam logic [WIDTH-1:0] SET_WORD = {WIDTH{DEIO_PRESET_LEVEL}};

    // reset release through two flops
    logic rstMeta_q;
    logic rstN;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    logic clrAct;
    logic setAct;
    assign clrAct = CLR_OK && aclr;
    assign setAct = SET_OK && aset;

    // buffer type selection and sleep
    logic diffIn;
    logic [WIDTH-1:0] inPin;
    assign diffIn = TRUE_DIFF || (PSEUDO_DIFF && DIR == DEIO_DIR_BIDIR);
    always_comb begin
        inPin = diffIn ? (padIn & ~padInN) : padIn;
        if (USE_SLEEP && HAS_IN && !sleepN) begin
            inPin = '0;
        end
    end

    logic capLoad;
    logic lchLoad;
    assign capLoad = !IS_DDR || !USE_CLKEN || captureEn;
    assign lchLoad = !IS_DDR || !USE_CLKEN || launchEn;

    // positive-edge path registers
    logic [WIDTH-1:0] riseCap_q, riseCap_d;
    logic [WIDTH-1:0] txHi_q, txHi_d;
    logic [WIDTH-1:0] txLo_q, txLo_d;
    logic [WIDTH-1:0] txFirst;
    logic [WIDTH-1:0] txSecond;
    logic outInv;
    assign outInv = IS_DDR && INVERT_OUT && DIR == DEIO_DIR_OUT;
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            txFirst[i] = IS_DDR ? txData[2*i] : txData[i];
            txSecond[i] = IS_DDR ? txData[2*i+1] : txData[i];
        end
        if (outInv) begin
            txFirst = ~txFirst;
            txSecond = ~txSecond;
        end
        riseCap_d = capLoad ? inPin : riseCap_q;
        txHi_d = lchLoad ? txFirst : txHi_q;
        txLo_d = lchLoad ? txSecond : txLo_q;
    end
    always_ff @(posedge clock or negedge rstN or posedge clrAct or posedge setAct) begin
        if (!rstN) begin
            riseCap_q <= INIT_WORD;
            txHi_q <= INIT_WORD;
            txLo_q <= INIT_WORD;
        end else if (clrAct) begin
            riseCap_q <= CLR_WORD;
            txHi_q <= CLR_WORD;
            txLo_q <= CLR_WORD;
        end else if (setAct) begin
            riseCap_q <= SET_WORD;
            txHi_q <= SET_WORD;
            txLo_q <= SET_WORD;
        end else begin
            riseCap_q <= riseCap_d;
            txHi_q <= txHi_d;
            txLo_q <= txLo_d;
        end
    end

    // negative-edge path registers
    logic [WIDTH-1:0] fallCap_q, fallCap_d;
    logic [WIDTH-1:0] realign_q, realign_d;
    logic [WIDTH-1:0] txLoN_q, txLoN_d;
    always_comb begin
        fallCap_d = capLoad ? inPin : fallCap_q;
        realign_d = capLoad ? riseCap_q : realign_q;
        txLoN_d = txLo_q;
    end
    always_ff @(negedge clock or negedge rstN or posedge clrAct or posedge setAct) begin
        if (!rstN) begin
            fallCap_q <= INIT_WORD;
            realign_q <= INIT_WORD;
            txLoN_q <= INIT_WORD;
        end else if (clrAct) begin
            fallCap_q <= CLR_WORD;
            realign_q <= CLR_WORD;
            txLoN_q <= CLR_WORD;
        end else if (setAct) begin
            fallCap_q <= SET_WORD;
            realign_q <= SET_WORD;
            txLoN_q <= SET_WORD;
        end else begin
            fallCap_q <= fallCap_d;
            realign_q <= realign_d;
            txLoN_q <= txLoN_d;
        end
    end

    // pad drive: value, enable, open drain, bus hold, differential
    logic [WIDTH-1:0] outVal;
    logic [WIDTH-1:0] hold_q, hold_d;
    logic drvEn;
    always_comb begin
        if (IS_BYP) begin
            outVal = txFirst;
        end else if (IS_DDR) begin
            outVal = clock ? txHi_q : txLoN_q;
        end else begin
            outVal = txHi_q;
        end
        drvEn = HAS_OUT && ((DIR == DEIO_DIR_BIDIR || USE_OE) ? oe : 1'b1);
        for (int i = 0; i < WIDTH; i++) begin
            if (OPEN_DRAIN) begin
                padOutEnN[i] = !(drvEn && !outVal[i]);
                padOut[i] = 1'b0;
            end else begin
                padOutEnN[i] = !drvEn;
                padOut[i] = drvEn ? outVal[i] : (BUS_HOLD ? hold_q[i] : 1'b0);
            end
        end
        padOutN = (TRUE_DIFF || PSEUDO_DIFF) ? ~padOut : '0;
        hold_d = drvEn ? outVal : hold_q;
    end
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            hold_q <= CLR_WORD;
        end else begin
            hold_q <= hold_d;
        end
    end

    // captured word and two-entry buffer toward the core
    logic [2*WIDTH-1:0] capWord;
    logic push;
    logic pop;
    always_comb begin
        capWord = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (IS_DDR && INVERT_INCLK) begin
                capWord[2*i] = fallCap_q[i];
                capWord[2*i+1] = inPin[i];
            end else if (IS_DDR) begin
                capWord[2*i] = realign_q[i];
                capWord[2*i+1] = fallCap_q[i];
            end else begin
                capWord[i] = riseCap_q[i];
            end
        end
    end

    logic [2*WIDTH-1:0] mem_q [DEIO_BUF_DEPTH];
    logic [2*WIDTH-1:0] mem_d [DEIO_BUF_DEPTH];
    logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [1:0] count_q, count_d;
    logic full;
    assign full = (count_q == 2'(DEIO_BUF_DEPTH));
    assign push = HAS_IN && !IS_BYP && rstN && capLoad && !full;
    assign pop = rxReady && (count_q != DEIO_EMPTY_COUNT);
    always_comb begin
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wrPtr_q] = capWord;
            wrPtr_d = !wrPtr_q;
        end
        if (pop) begin
            rdPtr_d = !rdPtr_q;
        end
        count_d = 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= DEIO_EMPTY_COUNT;
            captureReady <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            captureReady <= (count_d != 2'(DEIO_BUF_DEPTH));
        end
    end
    always_comb begin
        if (IS_BYP) begin
            rxData = {{WIDTH{1'b0}}, inPin};
            rxValid = HAS_IN;
        end else begin
            rxData = mem_q[rdPtr_q];
            rxValid = (count_q != DEIO_EMPTY_COUNT);
        end
    end

    // checks
    realign_track_a: assert property (@(posedge clock) disable iff (!rstN || clrAct || setAct)
        (IS_DDR && $past(capLoad) && $past(rstN) && !$past(clrAct) && !$past(setAct)) |-> realign_q == $past(riseCap_d))
        else $error("realign register lost the rise-edge bit");
    cap_enable_hold_a: assert property (@(posedge clock) disable iff (!rstN || clrAct || setAct)
        (IS_DDR && USE_CLKEN && !captureEn) |=> $stable(riseCap_q))
        else $error("capture register loaded with enable low");
    sequence launchSeq;
        IS_DDR && lchLoad && rstN;
    endsequence
    out_invert_a: assert property (@(posedge clock) disable iff (!rstN || clrAct || setAct)
        launchSeq |=> txHi_q[0] == ($past(txData[0]) ^ outInv))
        else $error("launched first bit has wrong polarity");
    clear_force_a: assert property (@(posedge clock) disable iff (!rstN)
        clrAct |-> (riseCap_q == CLR_WORD && fallCap_q == CLR_WORD && txHi_q == CLR_WORD))
        else $error("clear did not force zero");
    preset_force_a: assert property (@(posedge clock) disable iff (!rstN)
        (setAct && !clrAct) |-> (riseCap_q == SET_WORD && txLo_q == SET_WORD))
        else $error("preset did not force one");
    open_drain_a: assert property (@(posedge clock) disable iff (!rstN)
        OPEN_DRAIN |-> (padOut == '0 && (~padOutEnN & outVal) == '0))
        else $error("open drain drove a high level");
    oe_release_a: assert property (@(posedge clock) disable iff (!rstN)
        (DIR == DEIO_DIR_BIDIR && !oe) |-> padOutEnN == SET_WORD)
        else $error("pin driven with output enable low");
    sequence pushSeq;
        push ##1 1'b1;
    endsequence
    buf_valid_a: assert property (@(posedge clock) disable iff (!rstN)
        pushSeq |-> rxValid ##0 (!IS_BYP))
        else $error("pushed word not visible to core");
    bypass_wire_a: assert property (@(posedge clock) disable iff (!rstN)
        (IS_BYP && drvEn && !OPEN_DRAIN) |-> padOut == txFirst)
        else $error("bypass path is not a wire");
    second_bit_a: assert property (@(posedge clock) disable iff (!rstN || clrAct || setAct)
        launchSeq |=> txLo_q[0] == ($past(txData[1]) ^ outInv))
        else $error("launched second bit has wrong polarity");
    launch_hold_a: assert property (@(posedge clock) disable iff (!rstN || clrAct || setAct)
        (IS_DDR && USE_CLKEN && !launchEn) |=> ($stable(txHi_q) && $stable(txLo_q)))
        else $error("launch register loaded with enable low");
    fall_enable_hold_a: assert property (@(negedge clock) disable iff (!rstN || clrAct || setAct)
        (IS_DDR && USE_CLKEN && !captureEn) |=> $stable(fallCap_q))
        else $error("fall capture register loaded with enable low");
    clear_rest_a: assert property (@(posedge clock) disable iff (!rstN)
        clrAct |-> (realign_q == CLR_WORD && txLo_q == CLR_WORD && txLoN_q == CLR_WORD))
        else $error("clear left a path register set");
    drop_refuse_a: assert property (@(posedge clock) disable iff (!rstN)
        (count_q == 2'(DEIO_BUF_DEPTH) && !rxReady) |=> ($stable(count_q) && $stable(rdPtr_q)))
        else $error("full buffer took or lost a word");
    oe_drive_a: assert property (@(posedge clock) disable iff (!rstN)
        (DIR == DEIO_DIR_BIDIR && oe && !OPEN_DRAIN) |-> padOutEnN == '0)
        else $error("pin released with output enable high");
endmodule // deio_path

// ---- dv/deio_pad_model.sv ----
// pad-side model: drives single-ended pad levels for the capture path
// assumes the bench gives the level for each clock half on riseVal and fallVal
module deio_pad_model #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic [WIDTH-1:0] riseVal,
    input wire logic [WIDTH-1:0] fallVal,
    output logic [WIDTH-1:0] padIn,
    output logic [WIDTH-1:0] padInN
);
    timeunit 1ns;
    timeprecision 100ps;
    // single-ended pads: negative leg held low
    assign padInN = '0;
    // level for the rising-edge sample, set well inside the low phase
    always @(negedge clock) begin
        #2 padIn <= riseVal;
    end
    // level for the falling-edge sample, set well inside the high phase
    always @(posedge clock) begin
        #2 padIn <= fallVal;
    end
endmodule // deio_pad_model

// ---- dv/deio_path_tb_top.sv ----
// self-checking bench for the ddr bidirectional pad register path
// assumes default design parameters: bidir, ddr, clear, enables and sleep ports on
module deio_path_tb_top;
    import deio_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = DEIO_DEF_WIDTH;
    logic clock = 0, resetn = 0, aclr = 0, aset = 0, captureEn = 1, launchEn = 1;
    logic sleepN = 1, oe = 1, rxReady = 1;
    logic [2*W-1:0] txData = '0;
    logic [W-1:0] riseVal = '0, fallVal = '0;
    logic [W-1:0] padIn, padInN, padOut, padOutN, padOutEnN;
    logic [2*W-1:0] rxData;
    logic rxValid, captureReady;
    int fail_count = 0, n_checks = 0;
    always #5 clock = ~clock;
    deio_pad_model #(.WIDTH(W)) pads (.clock(clock), .riseVal(riseVal), .fallVal(fallVal),
        .padIn(padIn), .padInN(padInN));
    deio_path #(.WIDTH(W)) uut (.clock(clock), .resetn(resetn), .aclr(aclr), .aset(aset),
        .captureEn(captureEn), .launchEn(launchEn), .sleepN(sleepN), .oe(oe), .txData(txData),
        .padIn(padIn), .padInN(padInN), .padOut(padOut), .padOutN(padOutN),
        .padOutEnN(padOutEnN), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .captureReady(captureReady));
    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // expected core word: even bit from rising sample, odd from falling
    function automatic logic [7:0] pairUp(input logic [W-1:0] a, input logic [W-1:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < W; i++) begin
            r[2*i] = a[i];
            r[2*i+1] = b[i];
        end
        return r;
    endfunction
    function automatic logic [7:0] halfOf(input logic [7:0] d, input int off);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < W; i++) begin
            r[i] = d[2*i+off];
        end
        return r;
    endfunction
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic run_capture(input logic [W-1:0] a, input logic [W-1:0] b);
        riseVal = a;
        fallVal = b;
        settle(5);
        check(8'(rxValid), 8'h1);
        check(rxData, pairUp(a, b));
        check(rxData, pairUp(a, b));
    endtask
    task automatic run_full(input logic [W-1:0] a, input logic [W-1:0] b);
        int k;
        rxReady = 0;
        settle(5);
        check(8'(captureReady), 8'h0);
        check(8'(rxValid), 8'h1);
        check(rxData, pairUp(a, b));
        rxReady = 1;
        k = 0;
        while (captureReady !== 1'b1 && k < 8) begin
            settle(1);
            k++;
        end
        if (k == 8) begin
            check(8'(captureReady), 8'h1);
            report_and_stop();
        end
    endtask
    task automatic run_sleep();
        sleepN = 0;
        settle(5);
        check(rxData, 8'h0);
        sleepN = 1;
        settle(5);
    endtask
    // enable sampled on both edges: changed by non-blocking assignment
    task automatic run_hold(input logic [W-1:0] a, input logic [W-1:0] b);
        captureEn <= 1'b0;
        riseVal = a;
        fallVal = b;
        settle(3);
        check(8'(rxValid), 8'h0);
        captureEn <= 1'b1;
        settle(5);
        check(rxData, pairUp(a, b));
        check(8'(rxValid), 8'h1);
    endtask
    task automatic run_launch(input logic [7:0] d);
        txData = d;
        launchEn = 1;
        @(posedge clock);
        #3 check(8'(padOut), halfOf(d, 0));
        check(8'(padOutEnN), 8'h0);
        @(negedge clock);
        #3 check(8'(padOut), halfOf(d, 1));
        @(negedge clock);
        launchEn = 0;
        txData = ~d;
        @(posedge clock);
        #3 check(8'(padOut), halfOf(d, 0));
        @(negedge clock);
        launchEn = 1;
        aclr = 1;
        #2 check(8'(padOut), 8'h0);
        check(8'(padOut), 8'h0);
        @(negedge clock);
        aclr = 0;
    endtask
    task automatic run_release();
        oe = 0;
        settle(2);
        check(8'(padOutEnN), 8'hf);
        check(8'(padOutN), 8'h0);
        oe = 1;
        settle(2);
        check(8'(padOutEnN), 8'h0);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        resetn = 1;
        settle(4);
        run_capture(4'h5, 4'ha);
        run_capture(4'h3, 4'hc);
        run_full(4'h3, 4'hc);
        run_hold(4'h9, 4'h6);
        run_sleep();
        run_launch(8'h96);
        run_launch(8'h3c);
        run_release();
        report_and_stop();
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule // deio_path_tb_top
